// ---- rtl/gpiop_port.sv ----
// Eight-pin general-purpose port with pin interrupts and DMA trigger
// How it works
// - Each port instance has eight pins; four instances give thirty-two.
// - Direction bit 0 makes pin an input; value register holds its sample.
// - Direction bit 1 makes pin an output driven from value register.
// - Value register spans 256 word aliases; address bits 9:2 mask bits.
// - Writes change only value bits whose mask address bit is one.
// - Reads return value where mask bit is one, zero elsewhere.
// - Outputs read last written value, inputs read pin level; reset clears.
// - Interrupts trigger on rising, falling, both edges, or high/low level.
// - Sense 0 edge/1 level, dual 1 both, polarity 1 high/rising, unmask 1.
// - All unmasked pending pin conditions combine into one interrupt output.
// - Raw flag sets when condition met, regardless of unmask.
// - Gated flag equals raw flag AND unmask bit.
// - Level-mode raw flag clears itself when pin leaves active level.
// - Edge-mode raw flag stays set until software writes one to clear.
// - Any pin can be enabled as DMA trigger; its event requests transfer.
`timescale 1ns/1ps
`default_nettype none
module gpiop_port #(
  parameter int PINS = gpiop_pkg::PIN_W
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [gpiop_pkg::ADDR_W-1:0] ADDR,
  input wire logic [gpiop_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [gpiop_pkg::DATA_W-1:0] RDATA,
  input wire logic [PINS-1:0] PIN_IN,
  output logic [PINS-1:0] PIN_OUT,
  output logic [PINS-1:0] PIN_OE,
  output logic IRQ,
  output logic [PINS-1:0] DMA_REQ
);

  // Value alias window decode, used by read and write paths
  // The low 1 KB holds the 256 word aliases; control registers sit above it
  function automatic logic is_value(input logic [gpiop_pkg::ADDR_W-1:0] a);
    is_value = (a <= gpiop_pkg::OFF_VALUE_HI);
  endfunction

  logic [PINS-1:0] sync1_ff, sync2_ff, sync3_ff, prev_ff;
  logic [PINS-1:0] nxt_sync1, nxt_sync2, nxt_sync3, nxt_prev;
  logic [PINS-1:0] out_val_ff, dir_ff, sense_ff, dual_ff, pol_ff, unmask_ff, raw_ff, dma_en_ff;
  logic [PINS-1:0] nxt_out_val, nxt_dir, nxt_sense, nxt_dual, nxt_pol, nxt_unmask, nxt_raw, nxt_dma_en;
  logic [PINS-1:0] pin_now, mask, cond, edge_evt;
  logic [gpiop_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [PINS-1:0] pin_out_ff, pin_oe_ff, dma_ff, nxt_pin_out, nxt_pin_oe, nxt_dma;
  logic irq_ff, nxt_irq;

  // Three-stage synchroniser; the pin level changes once stages two and three agree
  // Limitation: a pin pulse shorter than about two clocks may never be seen
  // Stages reset low, so a pin idling high shows one rising edge after reset
  always_comb
  begin
    nxt_sync1 = PIN_IN;
    nxt_sync2 = sync1_ff;
    nxt_sync3 = sync2_ff;
    nxt_prev = pin_now;
  end

  // Accepted level only moves when the last two stages agree, filtering a single-cycle settle
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      pin_now[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : prev_ff[i];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      sync1_ff <= gpiop_pkg::RST_REG;
      sync2_ff <= gpiop_pkg::RST_REG;
      sync3_ff <= gpiop_pkg::RST_REG;
      prev_ff <= gpiop_pkg::RST_REG;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      sync3_ff <= nxt_sync3;
      prev_ff <= nxt_prev;
    end
  end

  // Address mask for the data aliases
  // Bit i of the mask gates data bit i on both reads and writes
  assign mask = ADDR[gpiop_pkg::MASK_MSB:gpiop_pkg::MASK_LSB];

  // Per-pin interrupt condition, generated for every pin of the port
  // Edge mode compares this cycle's accepted level with the last one
  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      logic rise, fall;
      assign rise = pin_now[g] & ~prev_ff[g];
      assign fall = ~pin_now[g] & prev_ff[g];
      // Level: active level; edge: chosen edge, or either when dual is set
      assign edge_evt[g] = dual_ff[g] ? (rise | fall) : (pol_ff[g] ? rise : fall);
      assign cond[g] = sense_ff[g] ? (pin_now[g] == pol_ff[g]) : edge_evt[g];
    end
  endgenerate

  // Register writes and flag upkeep
  always_comb
  begin
    nxt_out_val = out_val_ff;
    nxt_dir = dir_ff;
    nxt_sense = sense_ff;
    nxt_dual = dual_ff;
    nxt_pol = pol_ff;
    nxt_unmask = unmask_ff;
    nxt_dma_en = dma_en_ff;
    nxt_raw = raw_ff;
    if (WR)
    begin
      if (is_value(ADDR))
      begin
        nxt_out_val = (out_val_ff & ~mask) | (WDATA[PINS-1:0] & mask);
      end
      else if (ADDR == gpiop_pkg::OFF_DIR)
      begin
        nxt_dir = WDATA[PINS-1:0];
      end
      else if (ADDR == gpiop_pkg::OFF_SENSE)
      begin
        // Takes effect at once; an unmasked pin may flag spuriously here
        nxt_sense = WDATA[PINS-1:0];
      end
      else if (ADDR == gpiop_pkg::OFF_DUAL)
      begin
        nxt_dual = WDATA[PINS-1:0];
      end
      else if (ADDR == gpiop_pkg::OFF_POL)
      begin
        nxt_pol = WDATA[PINS-1:0];
      end
      else if (ADDR == gpiop_pkg::OFF_UNMASK)
      begin
        nxt_unmask = WDATA[PINS-1:0];
      end
      else if (ADDR == gpiop_pkg::OFF_CLEAR)
      begin
        // Only edge-mode flags are cleared by software
        nxt_raw = raw_ff & ~(WDATA[PINS-1:0] & ~sense_ff);
      end
      else if (ADDR == gpiop_pkg::OFF_DMA_EN)
      begin
        nxt_dma_en = WDATA[PINS-1:0];
      end
    end
    // Level pins follow the condition; edge pins latch, new event beats the clear
    // so an edge arriving with the clear write is never lost
    for (int i = 0; i < PINS; i++)
    begin
      if (sense_ff[i])
      begin
        nxt_raw[i] = cond[i];
      end
      else if (cond[i])
      begin
        nxt_raw[i] = 1'b1;
      end
    end
  end

  // Read data; the word stands one cycle after the strobe, zero otherwise
  always_comb
  begin
    logic [PINS-1:0] live;
    live = (dir_ff & out_val_ff) | (~dir_ff & pin_now);
    nxt_rdata = '0;
    if (RD)
    begin
      if (is_value(ADDR))
      begin
        nxt_rdata[PINS-1:0] = live & mask;
      end
      else if (ADDR == gpiop_pkg::OFF_DIR)
      begin
        nxt_rdata[PINS-1:0] = dir_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_SENSE)
      begin
        nxt_rdata[PINS-1:0] = sense_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_DUAL)
      begin
        nxt_rdata[PINS-1:0] = dual_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_POL)
      begin
        nxt_rdata[PINS-1:0] = pol_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_UNMASK)
      begin
        nxt_rdata[PINS-1:0] = unmask_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_RAW)
      begin
        nxt_rdata[PINS-1:0] = raw_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_GATED)
      begin
        nxt_rdata[PINS-1:0] = raw_ff & unmask_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_DMA_EN)
      begin
        nxt_rdata[PINS-1:0] = dma_en_ff;
      end
      else if (ADDR == gpiop_pkg::OFF_CLEAR)
      begin
        nxt_rdata = '0; // Write-only: clear strobes leave nothing to read back
      end
    end
  end

  // Read data register
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Pin-facing outputs, registered so the pads never see decode glitches
  always_comb
  begin
    nxt_pin_out = out_val_ff;
    nxt_pin_oe = dir_ff;
    nxt_irq = |(raw_ff & unmask_ff);
    // Edge conditions last one cycle, so each event asks for one transfer;
    // a flag still pending in software does not hold the next request back
    nxt_dma = dma_en_ff & cond;
  end

  // Pin-facing output registers
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      pin_out_ff <= gpiop_pkg::RST_REG;
      pin_oe_ff <= gpiop_pkg::RST_REG;
      dma_ff <= gpiop_pkg::RST_REG;
      irq_ff <= 1'b0;
    end
    else
    begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      dma_ff <= nxt_dma;
      irq_ff <= nxt_irq;
    end
  end

  // Control state registers; all clear at reset
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      out_val_ff <= gpiop_pkg::RST_REG;
      dir_ff <= gpiop_pkg::RST_REG;
      sense_ff <= gpiop_pkg::RST_REG;
      dual_ff <= gpiop_pkg::RST_REG;
      pol_ff <= gpiop_pkg::RST_REG;
      unmask_ff <= gpiop_pkg::RST_REG;
      raw_ff <= gpiop_pkg::RST_REG;
      dma_en_ff <= gpiop_pkg::RST_REG;
    end
    else
    begin
      out_val_ff <= nxt_out_val;
      dir_ff <= nxt_dir;
      sense_ff <= nxt_sense;
      dual_ff <= nxt_dual;
      pol_ff <= nxt_pol;
      unmask_ff <= nxt_unmask;
      raw_ff <= nxt_raw;
      dma_en_ff <= nxt_dma_en;
    end
  end

  assign RDATA = rdata_ff;
  assign PIN_OUT = pin_out_ff;
  assign PIN_OE = pin_oe_ff;
  assign IRQ = irq_ff;
  assign DMA_REQ = dma_ff;

endmodule
`default_nettype wire

// ---- common/gpiop_pkg.sv ----
// Register map and constants for the eight-pin general-purpose port
`default_nettype none
package gpiop_pkg;
  localparam int PIN_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Byte offsets of the port registers
  localparam logic [11:0] OFF_VALUE_LO = 12'h000;
  localparam logic [11:0] OFF_VALUE_HI = 12'h3FC;
  localparam logic [11:0] OFF_DIR = 12'h400;
  localparam logic [11:0] OFF_SENSE = 12'h404;
  localparam logic [11:0] OFF_DUAL = 12'h408;
  localparam logic [11:0] OFF_POL = 12'h40C;
  localparam logic [11:0] OFF_UNMASK = 12'h410;
  localparam logic [11:0] OFF_RAW = 12'h414;
  localparam logic [11:0] OFF_GATED = 12'h418;
  localparam logic [11:0] OFF_CLEAR = 12'h41C;
  localparam logic [11:0] OFF_DMA_EN = 12'h420;
  // Data-alias mask sits in address bits [9:2]
  localparam int MASK_LSB = 2;
  localparam int MASK_MSB = 9;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

// ---- dv/gpiop_port_monitor.sv ----
// Port-level assertions for the eight-pin port
`timescale 1ns/1ps
`default_nettype none
module gpiop_port_monitor (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE,
  input wire logic IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // Read data only in the slot after a read, masked by alias bits
  property p_idle; !RD |=> RDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_mrd; RD && ADDR[11:10] == 2'h0 |=> (RDATA[7:0] & ~$past(ADDR[9:2])) == 8'h0; endproperty
  a_mrd: assert property (p_mrd) else $error("masked bit read nonzero");
  // Output pins read back what they drive
  property p_ord; RD && ADDR[11:10] == 2'h0 |=> ((RDATA[7:0] ^ PIN_OUT) & PIN_OE & $past(ADDR[9:2])) == 8'h0; endproperty
  a_ord: assert property (p_ord) else $error("output read differs");
  property p_drd; RD && ADDR == 12'h400 |=> RDATA[7:0] == PIN_OE; endproperty
  a_drd: assert property (p_drd) else $error("direction read differs");
  // Direction and value writes reach the pads two edges later
  property p_dwr; WR && ADDR == 12'h400 ##1 !WR |=> PIN_OE == $past(WDATA[7:0], 2); endproperty
  a_dwr: assert property (p_dwr) else $error("enable not updated");
  property p_vwr; WR && ADDR[11:10] == 2'h0 ##1 !WR |=>
    ((PIN_OUT ^ $past(WDATA[7:0], 2)) & $past(ADDR[9:2], 2) & PIN_OE) == 8'h0; endproperty
  a_vwr: assert property (p_vwr) else $error("masked write lost");
  // Interrupt line agrees with the gated flags seen by a read
  property p_irq; RD && ADDR == 12'h418 |=> IRQ == (|RDATA[7:0]); endproperty
  a_irq: assert property (p_irq) else $error("irq differs from gated");
  property p_unm; RD && ADDR > 12'h420 |=> RDATA == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
endmodule
`default_nettype wire

// ---- dv/gpiop_pad_model.sv ----
// External pad drivers with read-back of driven pins
`timescale 1ns/1ps
`default_nettype none
module gpiop_pad_model (
  input wire logic [7:0] ext,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in
);
  // A driven pad shows the port's value, an undriven one the outside source
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule
`default_nettype wire

// ---- dv/gpiop_port_bench.sv ----
// Self-checking bench for the eight-pin port
`timescale 1ns/1ps
`default_nettype none
module gpiop_port_bench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] ext = 8'h00;
  int dma_hits = 0;
  logic [31:0] rdata;
  logic [7:0] pin_in, pin_out, pin_oe, dma;
  logic irq;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  gpiop_port u_gpiop_port (.CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .IRQ(irq), .DMA_REQ(dma));
  gpiop_pad_model u_gpiop_pad_model (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  initial
  begin
    forever #10 clock = ~clock;
  end
  // Count cycles with a trigger pulse, since each lasts one cycle; also hang guard
  always @(posedge clock)
  begin
    if (dma != 8'h00)
      dma_hits++;
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrt(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(n, {24'h0, e}, rdata);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 9; i++)
      rdc("reg", 12'h400 + 12'(4 * i), 8'h00);
    rdc("unmapped", 12'h424, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_data;
    wrt(12'h400, 8'hFF);
    wrt(12'h098, 8'hEB);
    rdc("alias all", 12'h3FC, 8'h22);
    rdc("alias 0C4", 12'h0C4, 8'h20);
    chk("pin out", 32'h22, {24'h0, pin_out});
    wrt(12'h400, 8'h00);
    ext <= 8'hA5;
    repeat (6) @(posedge clock);
    rdc("input", 12'h3FC, 8'hA5);
    $display("data path done");
  endtask
  task automatic t_edge;
    int base;
    ext <= 8'h00;
    wrt(12'h410, 8'h00);
    wrt(12'h40C, 8'h01);
    wrt(12'h408, 8'h04);
    wrt(12'h420, 8'h01);
    wrt(12'h41C, 8'hFF);
    base = dma_hits;
    wrt(12'h410, 8'h05);
    ext <= 8'h07;
    repeat (8) @(posedge clock);
    rdc("raw rise", 12'h414, 8'h05);
    chk("dma", 32'h1, dma_hits - base);
    ext <= 8'h00;
    repeat (8) @(posedge clock);
    wrt(12'h414, 8'h00);
    rdc("raw fall", 12'h414, 8'h07);
    rdc("gated", 12'h418, 8'h05);
    chk("irq on", 32'h1, {31'h0, irq});
    ext <= 8'h01;
    repeat (8) @(posedge clock);
    chk("dma again", 32'h2, dma_hits - base);
    ext <= 8'h00;
    repeat (8) @(posedge clock);
    wrt(12'h41C, 8'h05);
    rdc("raw clr", 12'h414, 8'h02);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("edge events done");
  endtask
  task automatic t_level;
    wrt(12'h410, 8'h00);
    wrt(12'h404, 8'h08);
    wrt(12'h40C, 8'h08);
    wrt(12'h41C, 8'hFF);
    wrt(12'h410, 8'h08);
    ext <= 8'h08;
    repeat (8) @(posedge clock);
    wrt(12'h41C, 8'h08);
    rdc("level held", 12'h414, 8'h08);
    chk("irq level on", 32'h1, {31'h0, irq});
    ext <= 8'h00;
    repeat (8) @(posedge clock);
    rdc("level gone", 12'h414, 8'h00);
    chk("irq level", 32'h0, {31'h0, irq});
    wrt(12'h410, 8'h00);
    wrt(12'h40C, 8'h00);
    rdc("level low", 12'h414, 8'h08);
    rdc("low masked", 12'h418, 8'h00);
    $display("level events done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_data();
    t_edge();
    t_level();
    wrap_up();
  end
endmodule
bind gpiop_port gpiop_port_monitor u_mon (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .IRQ(IRQ));
`default_nettype wire
